// >>> logic/gen_cfg_handler.sv
// Generator configuration command handler with Avalon-MM register slave
// Notes on behaviour
// R1 - Listing query returns quoted comma-separated names, empty quotes if none
// R2 - Four fixed waveform slots of up to 16k points each
// R3 - Free-slot query returns unused slot count, 0 to 4
// R4 - Normal order: high byte first, point assembled that way
// R5 - Swapped order: low byte first, point reassembled accordingly
// R6 - Point is 12 bits carried as two bytes on 8-bit port
// R7 - Byte order resets to normal; query reports normal or swapped
// R8 - Delete location 0-3; error 810 when location empty
// R9 - Location 0 cleared gives error 772 at next power-up
// R10 - Auto-recall restores location 0 at power-up and system reset
// R11 - Auto-recall off from factory; reads 0 off, 1 on
// R12 - Auto-recall flag is saved with location 0; host must save
// R13 - Saved state keeps non-volatile waveform selection, not volatile data
// R14 - Location 0 survives power loss and interface reset
// R15 - Termination 50 ohm or high-Z; min 50, max high-Z, reset 50
// R16 - Termination change doubles or halves amplitude and offset
// R17 - Sync enable gates sync output, on after reset, reads 0/1
// R18 - Disabled sync output level is undefined
// R19 - Immediate trigger pulses ext high and enabled lines low
// R20 - Trigger-state setting stored but changes nothing
// R21 - Eight line enables, off at reset, volatile, read 0 or 1
// R22 - Bad order, termination or location rejected with parameter error
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module gen_cfg_handler
  import gen_cfg_pkg::*;
#(
  parameter int LINES = 8
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Power-up and backplane system reset events
  input  wire logic              power_up,
  input  wire logic              sys_reset,
  // Avalon-MM slave
  input  wire logic [5:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Binary point byte stream
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  output logic                   point_valid,
  output logic      [11:0]       point_data,
  // Sync and trigger outputs
  input  wire logic              sync_src,
  output logic                   sync_out,
  output logic                   ext_trig,
  output logic      [LINES-1:0]  line_trig_n,
  // Output settings to analog path
  output logic                   load_highz,
  output logic      [15:0]       amplitude,
  output logic      [15:0]       offset_out
);

  typedef struct packed {
    logic [31:0]       rdata;
    logic              wait_n;
    logic [1:0]        order;
    logic              highz;
    logic              sync_en;
    logic              tstate;
    logic [LINES-1:0]  line_en;
    logic [15:0]       amp;
    logic [15:0]       ofs;
    logic [SLOT_COUNT-1:0] slot_used;
    logic [1:0]        cur_slot;
    logic              cur_nv;
    logic [STATE_LOCS-1:0] loc_valid;
    logic              auto_recall;
    logic              saved_auto;
    logic              saved_highz;
    logic              saved_sync;
    logic [15:0]       saved_amp;
    logic [15:0]       saved_ofs;
    logic [1:0]        saved_slot;
    logic              saved_nv;
    logic [9:0]        err;
    logic              have_hi;
    logic [7:0]        first;
    logic              pvalid;
    logic [11:0]       pdata;
    logic              sync_q;
    logic [7:0]        pulse_cnt;
    logic              ext;
    logic [LINES-1:0]  lines_n;
  } state_t;

  state_t st_reg, st_next;

  function automatic logic [2:0] free_count(input logic [3:0] used);
    free_count = 3'(!used[0]) + 3'(!used[1]) + 3'(!used[2]) + 3'(!used[3]);
  endfunction

  // Listing bytes: "name","name" with name = digit; byte index selects
  function automatic logic [7:0] listing_byte(input logic [3:0] used,
                                              input logic [4:0] idx);
    logic [7:0] b;
    logic [4:0] pos;
    logic       any;
    b   = CH_NUL;
    pos = 5'h00;
    any = |used;
    if (!any) begin
      if (idx < 5'h02) begin
        b = CH_QUOTE; // R1
      end
    end else begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        if (used[i]) begin
          if (pos != 5'h00 && idx == pos) begin
            b = CH_COMMA;
          end
          if (pos != 5'h00) begin
            pos = pos + 5'h01;
          end
          if (idx == pos || idx == pos + 5'h02) begin
            b = CH_QUOTE; // R1
          end
          if (idx == pos + 5'h01) begin
            b = CH_DIGIT0 + 8'(i);
          end
          pos = pos + 5'h03;
        end
      end
    end
    listing_byte = b;
  endfunction

  logic wr_hit, rd_hit;
  // Write lands at the edge where waitrequest is sampled low
  assign wr_hit = write && st_reg.wait_n;
  assign rd_hit = read && !st_reg.wait_n;

  always_comb begin
    st_next        = st_reg;
    st_next.wait_n = 1'b0;
    st_next.pvalid = 1'b0;
    st_next.sync_q = sync_src && st_reg.sync_en; // R17 R18
    // Trigger pulse timing
    if (st_reg.pulse_cnt != 8'h00) begin
      st_next.pulse_cnt = st_reg.pulse_cnt - 8'h01;
      if (st_reg.pulse_cnt == 8'h01) begin
        st_next.ext     = 1'b0;
        st_next.lines_n = '1;
      end
    end
    // Byte stream assembly
    if (byte_valid) begin
      if (!st_reg.have_hi) begin
        st_next.have_hi = 1'b1;
        st_next.first   = byte_data;
      end else begin
        st_next.have_hi = 1'b0;
        st_next.pvalid  = 1'b1; // R6
        if (st_reg.order == ORDER_SWAPPED) begin
          st_next.pdata = {byte_data[3:0], st_reg.first}; // R5
        end else begin
          st_next.pdata = {st_reg.first[3:0], byte_data}; // R4
        end
      end
    end
    // Recall on power-up or backplane system reset
    if (power_up || sys_reset) begin
      st_next.order   = ORDER_NORMAL;
      st_next.line_en = '0;
      st_next.tstate  = 1'b0;
      if (power_up && !st_reg.loc_valid[0]) begin
        st_next.err = ERR_CHECKSUM; // R9
      end
      if (st_reg.saved_auto && st_reg.loc_valid[0]) begin
        st_next.highz   = st_reg.saved_highz; // R10
        st_next.sync_en = st_reg.saved_sync;
        st_next.amp     = st_reg.saved_amp;
        st_next.ofs     = st_reg.saved_ofs;
        st_next.cur_slot = st_reg.saved_slot; // R13
        st_next.cur_nv  = st_reg.saved_nv &&
                          st_reg.slot_used[st_reg.saved_slot];
        st_next.auto_recall = 1'b1;
      end else begin
        st_next.highz   = 1'b0;
        st_next.sync_en = 1'b1;
        st_next.amp     = AMP_RESET;
        st_next.ofs     = OFS_RESET;
        st_next.cur_nv  = 1'b0;
        st_next.auto_recall = st_reg.saved_auto;
      end
    end
    // Bus access, one cycle wait then answer
    if (read || write) begin
      st_next.wait_n = !st_reg.wait_n;
    end
    if (rd_hit) begin
      unique case (address)
        CTRL_OFF: st_next.rdata =
          32'({st_reg.line_en, 2'h0, st_reg.tstate, st_reg.sync_en,
               1'b0, st_reg.highz, st_reg.order}); // R7 R15 R17 R21
        STATE_OFF: st_next.rdata =
          32'({st_reg.auto_recall, 4'h0, st_reg.loc_valid}); // R11
        SLOT_OFF: st_next.rdata =
          32'({st_reg.cur_nv, st_reg.cur_slot, st_reg.slot_used});
        FREE_OFF: st_next.rdata =
          32'(free_count(st_reg.slot_used)); // R3
        POINT_OFF: st_next.rdata = 32'(st_reg.pdata);
        ERR_OFF: st_next.rdata = 32'(st_reg.err);
        AMP_OFF: st_next.rdata = 32'(st_reg.amp);
        OFS_OFF: st_next.rdata = 32'(st_reg.ofs);
        LISTING_OFF, LISTING_OFF + 6'h04, LISTING_OFF + 6'h08,
        LISTING_OFF + 6'h0c: begin
          for (int k = 0; k < 4; k++) begin
            st_next.rdata[8*k +: 8] = listing_byte(st_reg.slot_used,
              5'({address[3:2] - 2'h1, 2'(k)})); // R1
          end
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (rd_hit && address == ERR_OFF) begin
      st_next.err = ERR_NONE;
    end
    if (wr_hit) begin
      unique case (address)
        CTRL_OFF: begin
          if (byteenable[0]) begin
            if (writedata[CTRL_ORDER_LSB +: 2] > ORDER_SWAPPED) begin
              st_next.err = ERR_PARAM; // R22
            end else begin
              st_next.order = writedata[CTRL_ORDER_LSB +: 2]; // R7
            end
            if (writedata[CTRL_LOAD_LSB +: 2] == LOAD_FIFTY ||
                writedata[CTRL_LOAD_LSB +: 2] == LOAD_MIN) begin
              st_next.highz = 1'b0; // R15
            end else begin
              st_next.highz = 1'b1; // R15
            end
            if (st_next.highz && !st_reg.highz) begin
              st_next.amp = {st_reg.amp[14:0], 1'b0}; // R16
              st_next.ofs = {st_reg.ofs[14:0], 1'b0};
            end else if (!st_next.highz && st_reg.highz) begin
              st_next.amp = {1'b0, st_reg.amp[15:1]}; // R16
              st_next.ofs = {st_reg.ofs[15], st_reg.ofs[15:1]};
            end
            st_next.sync_en = writedata[CTRL_SYNC_BIT]; // R17
            st_next.tstate  = writedata[CTRL_TSTATE_BIT]; // R20
          end
          if (byteenable[1]) begin
            st_next.line_en = writedata[CTRL_LINES_LSB +: LINES]; // R21
          end
        end
        TRIG_OFF: begin
          if (writedata[TRIG_FIRE_BIT]) begin
            st_next.ext       = 1'b1; // R19
            st_next.lines_n   = ~st_reg.line_en; // R19
            st_next.pulse_cnt = 8'(PULSE_CYCLES);
          end
        end
        STATE_OFF: begin
          st_next.auto_recall = writedata[STATE_AUTO_BIT]; // R11
          unique case (writedata[1:0])
            OP_SAVE: begin
              st_next.loc_valid[writedata[STATE_LOC_LSB +: 2]] = 1'b1;
              if (writedata[STATE_LOC_LSB +: 2] == 2'h0) begin
                st_next.saved_auto  = st_next.auto_recall; // R12 R14
                st_next.saved_highz = st_reg.highz;
                st_next.saved_sync  = st_reg.sync_en;
                st_next.saved_amp   = st_reg.amp;
                st_next.saved_ofs   = st_reg.ofs;
                st_next.saved_slot  = st_reg.cur_slot; // R13
                st_next.saved_nv    = st_reg.cur_nv;
              end
            end
            OP_DELETE: begin
              if (!st_reg.loc_valid[writedata[STATE_LOC_LSB +: 2]]) begin
                st_next.err = ERR_NO_STATE; // R8
              end
              st_next.loc_valid[writedata[STATE_LOC_LSB +: 2]] = 1'b0; // R8
            end
            default: begin
            end
          endcase
        end
        SLOT_OFF: begin
          unique case (writedata[SLOT_OP_LSB +: 2])
            OP_SAVE: st_next.slot_used[writedata[1:0]] = 1'b1; // R2
            OP_DELETE: st_next.slot_used[writedata[1:0]] = 1'b0; // R2
            OP_RECALL: begin
              st_next.cur_slot = writedata[1:0];
              st_next.cur_nv   = st_reg.slot_used[writedata[1:0]];
            end
            default: begin
            end
          endcase
        end
        AMP_OFF: st_next.amp = writedata[15:0];
        OFS_OFF: st_next.ofs = writedata[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_reg             <= '0;
      st_reg.sync_en     <= 1'b1; // R17
      st_reg.amp         <= AMP_RESET;
      st_reg.ofs         <= OFS_RESET;
      st_reg.lines_n     <= '1;
      st_reg.slot_used   <= st_next.slot_used; // R14
      st_reg.loc_valid   <= st_next.loc_valid; // R14
      st_reg.saved_auto  <= st_next.saved_auto;
      st_reg.saved_highz <= st_next.saved_highz;
      st_reg.saved_sync  <= st_next.saved_sync;
      st_reg.saved_amp   <= st_next.saved_amp;
      st_reg.saved_ofs   <= st_next.saved_ofs;
      st_reg.saved_slot  <= st_next.saved_slot;
      st_reg.saved_nv    <= st_next.saved_nv;
      st_reg.auto_recall <= st_next.saved_auto;
    end else begin
      st_reg <= st_next;
    end
  end

  assign readdata    = st_reg.rdata;
  assign waitrequest = !st_reg.wait_n;
  assign point_valid = st_reg.pvalid;
  assign point_data  = st_reg.pdata;
  assign sync_out    = st_reg.sync_q;
  assign ext_trig    = st_reg.ext;
  assign line_trig_n = st_reg.lines_n;
  assign load_highz  = st_reg.highz;
  assign amplitude   = st_reg.amp;
  assign offset_out  = st_reg.ofs;

endmodule // gen_cfg_handler

// >>> logic/gen_cfg_pkg.sv
// Constants and types for the generator configuration command handler
package gen_cfg_pkg;
  // Register byte offsets
  localparam logic [5:0] CTRL_OFF      = 6'h00;
  localparam logic [5:0] TRIG_OFF      = 6'h04;
  localparam logic [5:0] STATE_OFF     = 6'h08;
  localparam logic [5:0] SLOT_OFF      = 6'h0c;
  localparam logic [5:0] FREE_OFF      = 6'h10;
  localparam logic [5:0] POINT_OFF     = 6'h14;
  localparam logic [5:0] ERR_OFF       = 6'h18;
  localparam logic [5:0] AMP_OFF       = 6'h1c;
  localparam logic [5:0] OFS_OFF       = 6'h20;
  localparam logic [5:0] LISTING_OFF   = 6'h24;
  // CTRL field positions
  localparam int CTRL_ORDER_LSB  = 0;
  localparam int CTRL_LOAD_LSB   = 2;
  localparam int CTRL_SYNC_BIT   = 4;
  localparam int CTRL_TSTATE_BIT = 5;
  localparam int CTRL_LINES_LSB  = 8;
  // TRIG field positions
  localparam int TRIG_FIRE_BIT   = 0;
  // STATE write fields: op in [1:0], location in [5:4], autorecall [8]
  localparam int STATE_LOC_LSB   = 4;
  localparam int STATE_AUTO_BIT  = 8;
  localparam int STATE_SAVE_BIT  = 9;
  // SLOT write fields: slot [1:0], op [5:4] (1 store, 2 delete)
  localparam int SLOT_OP_LSB     = 4;
  // Encodings
  localparam logic [1:0] ORDER_NORMAL  = 2'h0;
  localparam logic [1:0] ORDER_SWAPPED = 2'h1;
  localparam logic [1:0] LOAD_FIFTY    = 2'h0;
  localparam logic [1:0] LOAD_HIGHZ    = 2'h1;
  localparam logic [1:0] LOAD_MIN      = 2'h2;
  localparam logic [1:0] LOAD_MAX      = 2'h3;
  localparam logic [1:0] OP_SAVE       = 2'h1;
  localparam logic [1:0] OP_DELETE     = 2'h2;
  localparam logic [1:0] OP_RECALL     = 2'h3;
  // Error codes
  localparam logic [9:0] ERR_NONE      = 10'h000;
  localparam logic [9:0] ERR_NO_STATE  = 10'h32a;
  localparam logic [9:0] ERR_CHECKSUM  = 10'h304;
  localparam logic [9:0] ERR_PARAM     = 10'h3ff;
  // Reset values
  localparam logic [15:0] AMP_RESET    = 16'h0064;
  localparam logic [15:0] OFS_RESET    = 16'h0000;
  localparam int SLOT_COUNT            = 4;
  localparam int SLOT_POINTS           = 16384;
  localparam int STATE_LOCS            = 4;
  // Trigger pulse width
  localparam int CLOCK_HZ              = 25_000_000;
  localparam int PULSE_NS              = 1000;
  localparam int PULSE_CYCLES =
    (PULSE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  // Listing characters
  localparam logic [7:0] CH_QUOTE      = 8'h22;
  localparam logic [7:0] CH_COMMA      = 8'h2c;
  localparam logic [7:0] CH_NUL        = 8'h00;
  localparam logic [7:0] CH_DIGIT0     = 8'h30;
endpackage

// >>> verif/gen_cfg_asserts.sv
// Port checker for the configuration handler
`timescale 1ns/100ps
module gen_cfg_asserts
  import gen_cfg_pkg::*;
#(
  parameter int LINES = 8
) (
  // Clock, reset, bus and outputs watched
  input wire logic             clock,
  input wire logic             rst_b,
  input wire logic [5:0]       address,
  input wire logic             read,
  input wire logic             write,
  input wire logic             waitrequest,
  input wire logic             byte_valid,
  input wire logic             point_valid,
  input wire logic             sync_src,
  input wire logic             sync_out,
  input wire logic             ext_trig,
  input wire logic [LINES-1:0] line_trig_n,
  input wire logic             load_highz,
  input wire logic [15:0]      amplitude
);
  logic [7:0] hi_reg;
  always_ff @(posedge clock)
    if (!rst_b) hi_reg <= 8'h00;
    else hi_reg <= ext_trig ? hi_reg + 8'h01 : 8'h00;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  AST_WAIT_LOW: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_EXT_WIDTH: assert property ($fell(ext_trig) |-> hi_reg == PULSE_CYCLES)
    else $error("trigger pulse width wrong");
  AST_TRIG_CAUSE: assert property ($rose(ext_trig) |-> $past(write && !waitrequest && address == TRIG_OFF))
    else $error("trigger pulse without fire write");
  AST_LINE_MATCH: assert property (line_trig_n != {LINES{1'b1}} |-> ext_trig)
    else $error("line pulse outside trigger pulse");
  AST_SYNC_GATE: assert property (!sync_src |=> !sync_out)
    else $error("sync output high without source");
  AST_POINT: assert property (point_valid |-> $past(byte_valid) ##1 !point_valid)
    else $error("point pulse without byte or too long");
  AST_AMP_DOUBLE: assert property ($rose(load_highz) |-> amplitude == ($past(amplitude) << 1))
    else $error("amplitude not doubled");
  AST_AMP_HALF: assert property ($fell(load_highz) && $past(rst_b) |-> amplitude == ($past(amplitude) >> 1))
    else $error("amplitude not halved");
endmodule // gen_cfg_asserts
bind gen_cfg_handler gen_cfg_asserts #(.LINES(LINES)) gen_cfg_asserts_inst (
  .clock, .rst_b, .address, .read, .write, .waitrequest, .byte_valid,
  .point_valid, .sync_src, .sync_out, .ext_trig, .line_trig_n,
  .load_highz, .amplitude);

// >>> verif/gen_cfg_host.sv
// Host partner: Avalon master and point byte sender
`timescale 1ns/100ps
module gen_cfg_host (
  // Clock
  input  wire logic        clock,
  // Avalon-MM master
  output logic [5:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata,
  output logic [3:0]       byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  // Point byte stream
  output logic             byte_valid,
  output logic [7:0]       byte_data
);
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  task automatic xfer(input logic w, input logic [5:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    address <= a;
    writedata <= wd;
    write <= w;
    read <= !w;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n == 100) tb.hang();
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic send_pt(input logic [11:0] p, input logic swap);
    logic [15:0] w;
    w = {4'h0, p};
    byte_valid <= 1'b1;
    byte_data <= swap ? w[7:0] : w[15:8];
    @(posedge clock);
    byte_data <= swap ? w[15:8] : w[7:0];
    @(posedge clock);
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
    @(posedge clock);
  endtask
endmodule // gen_cfg_host

// >>> verif/tb.sv
// Self-checking bench for the configuration handler
`timescale 1ns/100ps
module tb;
  import gen_cfg_pkg::*;
  logic        clock, rst_b, power_up, sys_reset, sync_src;
  logic [5:0]  address;
  logic        read, write, waitrequest, byte_valid, point_valid;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic [7:0]  byte_data, line_trig_n;
  logic [11:0] point_data;
  logic        sync_out, ext_trig, load_highz;
  logic [15:0] amplitude, offset_out;
  int          err_total, compares, n;
  gen_cfg_handler gen_cfg_handler_inst (.clock, .rst_b, .power_up,
    .sys_reset, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .byte_valid, .byte_data, .point_valid,
    .point_data, .sync_src, .sync_out, .ext_trig, .line_trig_n,
    .load_highz, .amplitude, .offset_out);
  gen_cfg_host gen_cfg_host_inst (.clock, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .byte_valid,
    .byte_data);
  always #20 clock = ~clock;
  task automatic stop_test();
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang();
    $display("ERROR %0t wait limit reached", $time);
    err_total++;
    stop_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    gen_cfg_host_inst.xfer(1'b1, a, d, x);
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] m, e);
    logic [31:0] x;
    gen_cfg_host_inst.xfer(1'b0, a, 32'h0, x);
    chk(x & m, e);
  endtask
  task automatic ev(input logic pu);
    power_up <= pu;
    sys_reset <= !pu;
    @(posedge clock);
    power_up <= 1'b0;
    sys_reset <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rst1();
    rst_b <= 1'b0;
    @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
  endtask
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    power_up = 1'b0;
    sys_reset = 1'b0;
    sync_src = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    ev(1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(SLOT_OFF, 32'h20 | i);
      wr(STATE_OFF, 32'h02 | (i << 4));
    end
    rc(ERR_OFF, 32'h0, 32'h0);
    rc(FREE_OFF, 32'h7, 32'h4);
    rc(LISTING_OFF, 32'hffffff, 32'h2222);
    wr(SLOT_OFF, 32'h12);
    rc(FREE_OFF, 32'h7, 32'h3);
    rc(LISTING_OFF, 32'hffffffff, 32'h223222);
    wr(SLOT_OFF, 32'h10);
    wr(SLOT_OFF, 32'h11);
    wr(SLOT_OFF, 32'h13);
    rc(FREE_OFF, 32'h7, 32'h0);
    rc(LISTING_OFF, 32'hffffffff, 32'h2c223022);
    wr(STATE_OFF, 32'h12);
    rc(ERR_OFF, 32'h3ff, ERR_NO_STATE);
    wr(STATE_OFF, 32'h11);
    wr(STATE_OFF, 32'h12);
    rc(ERR_OFF, 32'h3ff, ERR_NONE);
    rc(STATE_OFF, 32'hf, 32'h0);
    ev(1'b1);
    rc(ERR_OFF, 32'h3ff, ERR_CHECKSUM);
    rst1();
    rc(CTRL_OFF, 32'hff1f, 32'h0010);
    chk(amplitude, AMP_RESET);
    wr(CTRL_OFF, 32'h12);
    rc(ERR_OFF, 32'h3ff, ERR_PARAM);
    rc(CTRL_OFF, 32'h3, 32'h0);
    gen_cfg_host_inst.send_pt(12'habc, 1'b0);
    rc(POINT_OFF, 32'hfff, 32'habc);
    wr(CTRL_OFF, 32'h11);
    rc(CTRL_OFF, 32'h3, 32'h1);
    gen_cfg_host_inst.send_pt(12'h5a3, 1'b1);
    rc(POINT_OFF, 32'hfff, 32'h5a3);
    for (int i = 1; i < 5; i++) begin
      wr(CTRL_OFF, 32'h10 | ((i % 4) << 2));
      chk(load_highz, i % 2);
      chk(amplitude, (i % 2) ? 16'h00c8 : 16'h0064);
    end
    sync_src <= 1'b1;
    wr(CTRL_OFF, 32'h0);
    @(posedge clock);
    chk(sync_out, 1'b0);
    rc(CTRL_OFF, 32'h10, 32'h0);
    wr(CTRL_OFF, 32'hac30);
    @(posedge clock);
    chk(sync_out, 1'b1);
    chk(amplitude, 16'h0064);
    wr(TRIG_OFF, 32'h1);
    n = 0;
    for (int k = 0; k < 40; k++) begin
      if (ext_trig === 1'b1) n++;
      if (ext_trig === 1'b1 && n == 1) chk(line_trig_n, 8'h53);
      @(posedge clock);
    end
    chk(n, PULSE_CYCLES);
    wr(SLOT_OFF, 32'h32);
    wr(CTRL_OFF, 32'h1);
    wr(STATE_OFF, 32'h101);
    wr(SLOT_OFF, 32'h31);
    rc(SLOT_OFF, 32'h70, 32'h50);
    rst1();
    rc(CTRL_OFF, 32'h13, 32'h10);
    ev(1'b0);
    rc(CTRL_OFF, 32'h13, 32'h0);
    rc(SLOT_OFF, 32'h70, 32'h60);
    rc(STATE_OFF, 32'h101, 32'h101);
    rc(6'h3c, 32'hffffffff, 32'h0);
    stop_test();
  end
endmodule // tb
